// [rtl/csw_timers.sv]
// cyclic switch timers with supply fault shutdown control, AHB-Lite slave
//
// Operation
// - On-time code 0 stops the timer low and codes 1 to 5 run it with 0.1, 0.3, 1, 10 or 20 ms on-time.
// - On-time code 6 stops the timer with its output high, and code 7 is reserved.
// - Period codes 0 to 6 select 10, 20, 50, 100, 200 ms, 1 s or 2 s, and code 7 is reserved.
// - Software assigns a timer first, and writing a running on-time code starts it with no other command.
// - With cyclic sensing selected, clearing the switches in restart also clears the fields of both timers.
// - A timer used as wake source keeps serving cyclic sensing and cyclic wake together.
// - With the overvoltage disable bit clear a supply overvoltage turns all switches off, else they are kept.
// - With the undervoltage disable bit clear a supply undervoltage turns all switches off, else they are kept.
// - When a supply shutdown ends the switches return to their prior state if recovery is on, else stay off.
// - Reserved bits of the timer and shutdown registers read zero and ignore writes.
// - Both timer registers clear on power-on reset, soft reset and restart entry.
// - The shutdown register clears on power-on or soft reset and keeps its three bits on restart.
// - In cyclic sensing the wake input is sampled through a 16 us filter at the end of each on-time.
//
// Decided for this implementation: register access over AHB-Lite.
module csw_timers #(
	parameter int TICK_CYCLES = csw_pkg::TICK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic supply_ov_pin,
	input wire logic supply_uv_pin,
	input wire logic soft_reset_req,
	input wire logic restart_entry,
	input wire logic hs_cleared_restart,
	input wire logic cyclic_sense_active,
	input wire logic [1:0] timer_wake_en,
	input wire logic [3:0] hs_request,
	output logic [1:0] timer_out,
	output logic [1:0] wake_filter_window,
	output logic [1:0] wake_sample,
	output logic [1:0] cyclic_wake_event,
	output logic [3:0] hs_enable,
	output logic hs_supply_shutdown,
	output logic hs_clear_req
);

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [21:0] HADDR_HI_ZERO = 22'h000000;
	localparam int NTMR = 2;

	// ***************************************************************
	// register index decode
	// ***************************************************************
	function automatic logic [7:0] reg_idx(input logic [31:0] a);
		// upper bits must be zero, otherwise the address is unmapped
		reg_idx = (a[31:10] == HADDR_HI_ZERO) ? a[9:2] : 8'hff;
	endfunction : reg_idx

	// ***************************************************************
	// bus slave: zero wait state, always OKAY
	// ***************************************************************
	logic wr_pend_r;
	logic [7:0] wr_idx_r;
	logic addr_ok;
	logic [7:0] a_idx;

	assign a_idx = reg_idx(haddr);
	assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ) && (hsize <= HSIZE_WORD);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 8'h00;
		end else if (hready) begin
			wr_pend_r <= addr_ok && hwrite;
			wr_idx_r <= a_idx;
		end
	end

	// ***************************************************************
	// control registers
	// ***************************************************************
	logic [7:0] tmr_r [NTMR];
	logic [7:0] tmr_nxt [NTMR];
	logic [NTMR-1:0] tmr_load;
	logic [7:0] sw_r, sw_nxt;
	logic tmr_hw_clr;

	// hardware clears win over a software write in the same cycle
	assign tmr_hw_clr = soft_reset_req || restart_entry || (hs_cleared_restart && cyclic_sense_active);

	always_comb begin
		for (int i = 0; i < NTMR; i++) begin
			tmr_nxt[i] = tmr_r[i];
			tmr_load[i] = 1'b0;
			if (tmr_hw_clr) begin
				tmr_nxt[i] = csw_pkg::RESET_VALUE;
				tmr_load[i] = 1'b1;
			end else if (wr_pend_r && wr_idx_r == csw_pkg::IDX_TMR_A + 8'(i)) begin
				tmr_nxt[i] = hwdata[7:0] & csw_pkg::TMR_MASK;
				tmr_load[i] = 1'b1;
			end
		end
		sw_nxt = sw_r;
		if (soft_reset_req) begin
			sw_nxt = csw_pkg::RESET_VALUE;
		end else if (wr_pend_r && wr_idx_r == csw_pkg::IDX_SW_SD) begin
			sw_nxt = hwdata[7:0] & csw_pkg::SW_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NTMR; i++) begin
				tmr_r[i] <= csw_pkg::RESET_VALUE;
			end
		end else begin
			for (int i = 0; i < NTMR; i++) begin
				tmr_r[i] <= tmr_nxt[i];
			end
		end
	end

	// restart entry leaves the shutdown bits alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_r <= csw_pkg::RESET_VALUE;
		end else begin
			sw_r <= sw_nxt;
		end
	end

	// ***************************************************************
	// time base tick shared by both timers
	// ***************************************************************
	logic [csw_pkg::TICK_W-1:0] tick_cnt_r;
	logic tick_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == csw_pkg::TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// ***************************************************************
	// timers
	// ***************************************************************
	csw_tmr_if tif[NTMR] ();
	logic [NTMR-1:0] t_out, t_win, t_samp;

	genvar g;
	generate
		for (g = 0; g < NTMR; g++) begin : g_tmr
			assign tif[g].tick = tick_r;
			assign tif[g].load = tmr_load[g];
			assign tif[g].on_code = tmr_nxt[g][csw_pkg::ON_MSB:csw_pkg::ON_LSB];
			assign tif[g].per_code = tmr_nxt[g][csw_pkg::PER_MSB:csw_pkg::PER_LSB];
			assign t_out[g] = tif[g].out_lvl;
			assign t_win[g] = tif[g].filt_win;
			assign t_samp[g] = tif[g].sample;
			csw_cyc_timer u_tmr (
				.hclk(hclk),
				.hresetn(hresetn),
				.t(tif[g])
			);
		end
	endgenerate

	// sensing and wake run from the same sample, neither gates the other
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_out <= 2'h0;
			wake_filter_window <= 2'h0;
			wake_sample <= 2'h0;
			cyclic_wake_event <= 2'h0;
		end else begin
			timer_out <= t_out;
			wake_filter_window <= t_win;
			wake_sample <= t_samp;
			cyclic_wake_event <= t_samp & timer_wake_en;
		end
	end

	// ***************************************************************
	// supply fault inputs: three stages, change once stages 2 and 3 agree
	// ***************************************************************
	logic [2:0] ov_s_r, uv_s_r;
	logic ov_f_r, uv_f_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ov_s_r <= 3'h0;
			uv_s_r <= 3'h0;
			ov_f_r <= 1'b0;
			uv_f_r <= 1'b0;
		end else begin
			ov_s_r <= {ov_s_r[1:0], supply_ov_pin};
			uv_s_r <= {uv_s_r[1:0], supply_uv_pin};
			if (ov_s_r[1] == ov_s_r[2]) begin
				ov_f_r <= ov_s_r[2];
			end
			if (uv_s_r[1] == uv_s_r[2]) begin
				uv_f_r <= uv_s_r[2];
			end
		end
	end

	// ***************************************************************
	// switch shutdown and recovery
	// ***************************************************************
	logic shut, shut_prev_r, latched_off_r;

	assign shut = (ov_f_r && !sw_r[csw_pkg::OV_DIS_BIT])
		|| (uv_f_r && !sw_r[csw_pkg::UV_DIS_BIT]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shut_prev_r <= 1'b0;
			latched_off_r <= 1'b0;
			hs_clear_req <= 1'b0;
		end else begin
			shut_prev_r <= shut;
			hs_clear_req <= 1'b0;
			if (shut_prev_r && !shut && !sw_r[csw_pkg::REC_EN_BIT]) begin
				// no recovery: keep off until the switch settings are cleared
				latched_off_r <= 1'b1;
				hs_clear_req <= 1'b1;
			end else if (hs_request == 4'h0) begin
				latched_off_r <= 1'b0;
			end
		end
	end

	// switch settings outside are untouched, so recovery restores the prior state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hs_enable <= 4'h0;
			hs_supply_shutdown <= 1'b0;
		end else begin
			// the cycle a fault ends without recovery must not pass the request through
			hs_enable <= (shut || latched_off_r || (shut_prev_r && !sw_r[csw_pkg::REC_EN_BIT]))
				? 4'h0 : hs_request;
			hs_supply_shutdown <= shut;
		end
	end

	// ***************************************************************
	// read path: data from next-state values so a write just done reads back
	// ***************************************************************
	logic [7:0] rd_byte;

	always_comb begin
		case (a_idx)
			csw_pkg::IDX_TMR_A: rd_byte = tmr_nxt[0] & csw_pkg::TMR_MASK;
			csw_pkg::IDX_TMR_B: rd_byte = tmr_nxt[1] & csw_pkg::TMR_MASK;
			csw_pkg::IDX_SW_SD: rd_byte = sw_nxt & csw_pkg::SW_MASK;
			csw_pkg::IDX_STATUS: rd_byte = {2'h0, latched_off_r, shut, t_win, t_out};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_ok && !hwrite) begin
				hrdata <= {24'h000000, rd_byte};
			end
		end
	end

endmodule : csw_timers

// [rtl/csw_pkg.sv]
// constants, field layouts and time tables for the cyclic switch timers
package csw_pkg;

	// ***************************************************************
	// clock and time base
	// ***************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_NS = 100000;
	localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_US = TICK_TIME_NS / 1000;
	localparam int FILTER_TIME_NS = 16000;
	localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 14;
	localparam int CNT_W = 15;
	localparam int FLT_W = 11;

	// on-times in microseconds, periods in milliseconds
	localparam int ON1_US = 100;
	localparam int ON2_US = 300;
	localparam int ON3_US = 1000;
	localparam int ON4_US = 10000;
	localparam int ON5_US = 20000;
	localparam int PER0_MS = 10;
	localparam int PER1_MS = 20;
	localparam int PER2_MS = 50;
	localparam int PER3_MS = 100;
	localparam int PER4_MS = 200;
	localparam int PER5_MS = 1000;
	localparam int PER6_MS = 2000;

	// ***************************************************************
	// register map: printed offsets are indices, byte address = 4 * index
	// ***************************************************************
	localparam logic [7:0] IDX_TMR_A = 8'h0c;
	localparam logic [7:0] IDX_TMR_B = 8'h0d;
	localparam logic [7:0] IDX_SW_SD = 8'h10;
	localparam logic [7:0] IDX_STATUS = 8'h11;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam int ON_LSB = 4;
	localparam int ON_MSB = 6;
	localparam int PER_LSB = 0;
	localparam int PER_MSB = 2;
	localparam int OV_DIS_BIT = 6;
	localparam int UV_DIS_BIT = 5;
	localparam int REC_EN_BIT = 4;
	localparam logic [7:0] TMR_MASK = 8'h77;
	localparam logic [7:0] SW_MASK = 8'h70;

	localparam logic [2:0] ON_STOP_LOW = 3'h0;
	localparam logic [2:0] ON_STOP_HIGH = 3'h6;
	localparam logic [2:0] ON_RSVD = 3'h7;
	localparam logic [2:0] PER_RSVD = 3'h7;

	typedef enum logic [1:0] {
		ST_STOP_LOW = 2'b00,
		ST_STOP_HIGH = 2'b01,
		ST_ON = 2'b10,
		ST_OFF = 2'b11
	} csw_tmr_state_e;

	// ***************************************************************
	// decoders
	// ***************************************************************
	function automatic logic [CNT_W-1:0] on_ticks(input logic [2:0] code);
		case (code)
			3'h1: on_ticks = CNT_W'(ON1_US / TICK_US);
			3'h2: on_ticks = CNT_W'(ON2_US / TICK_US);
			3'h3: on_ticks = CNT_W'(ON3_US / TICK_US);
			3'h4: on_ticks = CNT_W'(ON4_US / TICK_US);
			3'h5: on_ticks = CNT_W'(ON5_US / TICK_US);
			default: on_ticks = '0;
		endcase
	endfunction : on_ticks

	function automatic logic [CNT_W-1:0] per_ticks(input logic [2:0] code);
		case (code)
			3'h0: per_ticks = CNT_W'(PER0_MS * 1000 / TICK_US);
			3'h1: per_ticks = CNT_W'(PER1_MS * 1000 / TICK_US);
			3'h2: per_ticks = CNT_W'(PER2_MS * 1000 / TICK_US);
			3'h3: per_ticks = CNT_W'(PER3_MS * 1000 / TICK_US);
			3'h4: per_ticks = CNT_W'(PER4_MS * 1000 / TICK_US);
			3'h5: per_ticks = CNT_W'(PER5_MS * 1000 / TICK_US);
			3'h6: per_ticks = CNT_W'(PER6_MS * 1000 / TICK_US);
			default: per_ticks = '0;
		endcase
	endfunction : per_ticks

	function automatic logic tmr_running(input logic [2:0] on, input logic [2:0] per);
		tmr_running = (on != ON_STOP_LOW) && (on != ON_STOP_HIGH) && (on != ON_RSVD) && (per != PER_RSVD);
	endfunction : tmr_running

endpackage : csw_pkg

// [rtl/csw_tmr_if.sv]
// link between the register block and one cyclic timer
interface csw_tmr_if;
	logic tick;
	logic load;
	logic [2:0] on_code;
	logic [2:0] per_code;
	logic out_lvl;
	logic on_end;
	logic filt_win;
	logic sample;

	modport ctl (output tick, load, on_code, per_code, input out_lvl, on_end, filt_win, sample);
	modport tmr (input tick, load, on_code, per_code, output out_lvl, on_end, filt_win, sample);
endinterface : csw_tmr_if

// [rtl/csw_cyc_timer.sv]
// one cyclic timer: on-time / period sequencer with wake sample window
module csw_cyc_timer (
	input wire logic hclk,
	input wire logic hresetn,
	csw_tmr_if.tmr t
);

	// ***************************************************************
	// sequencer
	// ***************************************************************
	csw_pkg::csw_tmr_state_e state_r, state_nxt;
	logic [csw_pkg::CNT_W-1:0] cnt_r, cnt_nxt, cnt_inc, on_t, per_t;
	logic end_nxt;
	logic [csw_pkg::FLT_W-1:0] flt_r;
	logic out_r, end_r, samp_r;

	localparam logic [csw_pkg::FLT_W-1:0] FLT_ONE = 11'h001;

	always_comb begin
		on_t = csw_pkg::on_ticks(t.on_code);
		per_t = csw_pkg::per_ticks(t.per_code);
		cnt_inc = cnt_r + 1'b1;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		end_nxt = 1'b0;
		if (t.load) begin
			// a running code restarts the cycle at once, no start command
			cnt_nxt = '0;
			if (csw_pkg::tmr_running(t.on_code, t.per_code)) begin
				state_nxt = csw_pkg::ST_ON;
			end else if (t.on_code == csw_pkg::ON_STOP_HIGH) begin
				state_nxt = csw_pkg::ST_STOP_HIGH;
			end else begin
				// reserved codes park low rather than run an undefined cycle
				state_nxt = csw_pkg::ST_STOP_LOW;
			end
		end else if (t.tick) begin
			case (state_r)
				csw_pkg::ST_ON: begin
					cnt_nxt = cnt_inc;
					if (cnt_inc >= per_t) begin
						// on-time not shorter than period: stays high, still samples
						cnt_nxt = '0;
						end_nxt = 1'b1;
					end else if (cnt_inc >= on_t) begin
						state_nxt = csw_pkg::ST_OFF;
						end_nxt = 1'b1;
					end
				end
				csw_pkg::ST_OFF: begin
					cnt_nxt = cnt_inc;
					if (cnt_inc >= per_t) begin
						cnt_nxt = '0;
						state_nxt = csw_pkg::ST_ON;
					end
				end
				default: begin
					cnt_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= csw_pkg::ST_STOP_LOW;
			cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_r <= 1'b0;
			end_r <= 1'b0;
		end else begin
			out_r <= (state_nxt == csw_pkg::ST_ON) || (state_nxt == csw_pkg::ST_STOP_HIGH);
			end_r <= end_nxt;
		end
	end

	// ***************************************************************
	// 16 us wake filter window after each on-time end
	// ***************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flt_r <= '0;
			samp_r <= 1'b0;
		end else begin
			samp_r <= (flt_r == FLT_ONE);
			if (t.load) begin
				flt_r <= '0;
			end else if (end_r) begin
				flt_r <= csw_pkg::FLT_W'(csw_pkg::FILTER_CYCLES);
			end else if (flt_r != '0) begin
				flt_r <= flt_r - 1'b1;
			end
		end
	end

	assign t.out_lvl = out_r;
	assign t.on_end = end_r;
	assign t.filt_win = (flt_r != '0);
	assign t.sample = samp_r;

endmodule : csw_cyc_timer

// [test/csw_timers_props.sv]
// property checker bound to the cyclic switch timers
module csw_timers_props #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic soft_reset_req,
	input wire logic restart_entry,
	input wire logic hs_cleared_restart,
	input wire logic cyclic_sense_active,
	input wire logic [1:0] timer_wake_en,
	input wire logic [3:0] hs_request,
	input wire logic [1:0] timer_out,
	input wire logic [1:0] wake_filter_window,
	input wire logic [1:0] wake_sample,
	input wire logic [1:0] cyclic_wake_event,
	input wire logic [3:0] hs_enable,
	input wire logic hs_supply_shutdown,
	input wire logic hs_clear_req
);
	logic rd_r;
	logic wr_a_r;
	logic [7:0] idx_r;
	logic [2:0] on_a_r;
	logic hw_clr;
	logic [11:0] low_cnt_r;
	// 1600-cycle filter window plus the output register stage, counted from the output falling
	localparam logic [11:0] WIN_END = 12'h641;
	assign hw_clr = soft_reset_req || restart_entry || (hs_cleared_restart && cyclic_sense_active);
	// cycles since timer a output went low, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt_r <= 12'h000;
		end else if (timer_out[0]) begin
			low_cnt_r <= 12'h000;
		end else if (low_cnt_r != 12'hfff) begin
			low_cnt_r <= low_cnt_r + 12'h001;
		end
	end
	// address phase kept so the data phase knows what was asked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_r <= 1'b0;
			wr_a_r <= 1'b0;
			idx_r <= 8'h00;
		end else begin
			rd_r <= hsel && hready && htrans[1] && !hwrite;
			wr_a_r <= hsel && hready && htrans[1] && hwrite && haddr == 32'h30;
			idx_r <= haddr[9:2];
		end
	end
	// shadow of the timer a on-time code; a hardware clear beats a write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			on_a_r <= 3'h0;
		end else if (hw_clr) begin
			on_a_r <= 3'h0;
		end else if (wr_a_r) begin
			on_a_r <= hwdata[6:4];
		end
	end
	// ********************
	// properties
	// ********************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd_tmr;
		rd_r && (idx_r == csw_pkg::IDX_TMR_A || idx_r == csw_pkg::IDX_TMR_B);
	endsequence
	sequence s_win_done;
		low_cnt_r == WIN_END && !wake_filter_window[0];
	endsequence
	property p_tmr_rsvd;
		s_rd_tmr |-> hrdata[31:7] == 25'h0 && !hrdata[3];
	endproperty
	a_tmr_rsvd: assert property (p_tmr_rsvd) else $error("timer reserved bit set");
	property p_sw_rsvd;
		rd_r && idx_r == csw_pkg::IDX_SW_SD |-> hrdata[31:7] == 25'h0 && hrdata[3:0] == 4'h0;
	endproperty
	a_sw_rsvd: assert property (p_sw_rsvd) else $error("shutdown reserved bit set");
	property p_hold_high;
		(on_a_r == csw_pkg::ON_STOP_HIGH) [*3] |-> timer_out[0];
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("timer a not held high");
	property p_hold_low;
		(on_a_r == csw_pkg::ON_STOP_LOW || on_a_r == csw_pkg::ON_RSVD) [*3] |-> !timer_out[0];
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("timer a not held low");
	property p_restart;
		restart_entry |-> ##3 !timer_out[0];
	endproperty
	a_restart: assert property (p_restart) else $error("timer a runs after restart");
	property p_shut_off;
		hs_supply_shutdown [*2] |-> hs_enable == 4'h0;
	endproperty
	a_shut_off: assert property (p_shut_off) else $error("switch on in shutdown");
	property p_clr;
		hs_clear_req |-> hs_enable == 4'h0 ##1 !hs_clear_req;
	endproperty
	a_clr: assert property (p_clr) else $error("clear request wrong");
	property p_recover;
		$fell(hs_supply_shutdown) |-> ##[0:3] (hs_clear_req || hs_enable == hs_request);
	endproperty
	a_recover: assert property (p_recover) else $error("no recovery decision");
	property p_window;
		wake_sample[0] && !timer_out[0] |-> s_win_done;
	endproperty
	a_window: assert property (p_window) else $error("wake filter window length");
	property p_wake_evt;
		$rose(wake_sample[0]) && timer_wake_en[0] && $past(timer_wake_en[0]) |-> cyclic_wake_event[0];
	endproperty
	a_wake_evt: assert property (p_wake_evt) else $error("wake event missing");
endmodule : csw_timers_props

bind csw_timers csw_timers_props #(.TICK_CYCLES(TICK_CYCLES)) csw_timers_props_inst (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .soft_reset_req,
	.restart_entry, .hs_cleared_restart, .cyclic_sense_active, .timer_wake_en, .hs_request, .timer_out,
	.wake_filter_window, .wake_sample, .cyclic_wake_event, .hs_enable, .hs_supply_shutdown, .hs_clear_req
);

// [test/tb_csw_timers.sv]
// self-checking bench for the cyclic switch timers
module tb_csw_timers;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps the 1 s period inside the run
	localparam int TK = 2;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic supply_ov_pin = 1'b0;
	logic supply_uv_pin = 1'b0;
	logic soft_reset_req = 1'b0;
	logic restart_entry = 1'b0;
	logic hs_cleared_restart = 1'b0;
	logic cyclic_sense_active = 1'b0;
	logic [1:0] timer_wake_en = 2'h0;
	logic [3:0] hs_request = 4'h0;
	logic [1:0] timer_out;
	logic [1:0] wake_filter_window;
	logic [1:0] wake_sample;
	logic [1:0] cyclic_wake_event;
	logic [3:0] hs_enable;
	logic hs_supply_shutdown;
	logic hs_clear_req;
	logic [31:0] q;
	int bad_count = 0;
	int cmp_count = 0;
	// on-time and period in ticks times TK
	int onv [6] = '{1, 2, 3, 4, 5, 1};
	int pcv [6] = '{0, 1, 2, 3, 4, 5};
	int onc [6] = '{2, 6, 20, 200, 400, 2};
	int pcc [6] = '{200, 400, 1000, 2000, 4000, 20000};
	logic [7:0] sv [6] = '{8'h00, 8'h40, 8'h00, 8'h20, 8'h10, 8'h10};
	logic [1:0] pv [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
	logic [3:0] dv [6] = '{4'h0, 4'hf, 4'h0, 4'hf, 4'h0, 4'h0};
	logic [3:0] av [6] = '{4'h0, 4'hf, 4'h0, 4'hf, 4'hf, 4'hf};
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	csw_timers #(.TICK_CYCLES(TK)) csw_timers_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
		.supply_ov_pin, .supply_uv_pin, .soft_reset_req, .restart_entry, .hs_cleared_restart, .cyclic_sense_active,
		.timer_wake_en, .hs_request, .timer_out, .wake_filter_window, .wake_sample, .cyclic_wake_event, .hs_enable,
		.hs_supply_shutdown, .hs_clear_req
	);
	// ********************
	// tasks
	// ********************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 8'h00);
		chk(nm, q, e);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : rdc
	task automatic pulse(input int k);
		case (k)
			0: soft_reset_req <= 1'b1;
			1: restart_entry <= 1'b1;
			default: hs_cleared_restart <= 1'b1;
		endcase
		@(posedge hclk);
		{soft_reset_req, restart_entry, hs_cleared_restart} <= 3'h0;
		cyc(2);
	endtask : pulse
	task automatic meas(input int i, input int k);
		int hi;
		int wn;
		int ev;
		hi = 0;
		wn = 0;
		ev = 0;
		xfer(1'b1, 32'h30 + 32'(4 * i), 8'(onv[k] * 16 + pcv[k]));
		// first period skipped: the tick phase is not aligned to the write
		cyc(pcc[k] + 8);
		repeat (pcc[k]) begin
			@(posedge hclk);
			hi += timer_out[i];
			wn += wake_filter_window[i];
			ev += cyclic_wake_event[i];
		end
		chk("timer_high", hi, onc[k]);
		if (pcc[k] > 1600) begin
			chk("wake_window", wn, 1600);
			chk("wake_events", ev, 1);
		end
	endtask : meas
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	// ********************
	// tests
	// ********************
	initial begin
		cyc(16);
		hresetn <= 1'b1;
		cyc(1);
		rdc("tmr_a", 32'h30, 32'h0);
		rdc("tmr_b", 32'h34, 32'h0);
		rdc("sw", 32'h40, 32'h0);
		rdc("unmapped", 32'h430, 32'h0);
		xfer(1'b1, 32'h30, 8'hff);
		xfer(1'b1, 32'h34, 8'hff);
		xfer(1'b1, 32'h40, 8'hff);
		xfer(1'b1, 32'h430, 8'h55);
		rdc("tmr_a", 32'h30, 32'h77);
		rdc("tmr_b", 32'h34, 32'h77);
		rdc("sw", 32'h40, 32'h70);
		chk("rsvd_code_out", timer_out, 2'h0);
		pulse(1);
		rdc("tmr_a", 32'h30, 32'h0);
		rdc("tmr_b", 32'h34, 32'h0);
		rdc("sw", 32'h40, 32'h70);
		xfer(1'b1, 32'h30, 8'h11);
		pulse(0);
		rdc("tmr_a", 32'h30, 32'h0);
		rdc("sw", 32'h40, 32'h0);
		$display("register tests done");
		xfer(1'b1, 32'h30, 8'h60);
		xfer(1'b1, 32'h34, 8'h60);
		cyc(3);
		chk("stop_high", timer_out, 2'h3);
		pulse(2);
		rdc("tmr_a", 32'h30, 32'h60);
		cyclic_sense_active <= 1'b1;
		pulse(2);
		rdc("tmr_a", 32'h30, 32'h0);
		rdc("tmr_b", 32'h34, 32'h0);
		chk("cleared_out", timer_out, 2'h0);
		$display("restart tests done");
		hs_request <= 4'hf;
		for (int k = 0; k < 6; k++) begin
			xfer(1'b1, 32'h40, sv[k]);
			{supply_ov_pin, supply_uv_pin} <= pv[k];
			cyc(10);
			chk("hs_in_fault", hs_enable, dv[k]);
			{supply_ov_pin, supply_uv_pin} <= 2'h0;
			cyc(10);
			chk("hs_after_fault", hs_enable, av[k]);
			hs_request <= 4'h0;
			cyc(4);
			hs_request <= 4'hf;
			cyc(4);
		end
		chk("hs_released", hs_enable, 4'hf);
		$display("supply tests done");
		timer_wake_en <= 2'h1;
		for (int k = 0; k < 6; k++) meas(0, k);
		meas(1, 0);
		$display("timer tests done");
		give_verdict();
	end
	// about one and a half times the length of the tests, under the cycle budget
	initial begin
		#900000;
		bad_count++;
		give_verdict();
	end
endmodule : tb_csw_timers
